// ===== adc_mode_sequencer_serial_ctrl.sv
// mode sequencer, conversion/calibration engine and serial register port
//
// Summary of operation
// [RULE_01] idle after reset, calibration, single conversion
// [RULE_02] continuous: store result, set ready, next channel
// [RULE_03] continuous cycles enabled channels until mode change
// [RULE_04] scan period sums enabled channel conversion times
// [RULE_05] single done: data, ready, pin low, idle
// [RULE_06] single conversion ignores channel enable bit
// [RULE_07] standby powers down converter, serial stays live
// [RULE_08] clock output disable independent of standby
// [RULE_09] self calibration updates zero cal, all ready
// [RULE_10] system zero calibration updates channel, all ready
// [RULE_11] system full calibration updates channel, all ready
// [RULE_12] chip select high ignores serial, output floats
// [RULE_13] ready pin always driven
// [RULE_14] no continuous read on two wire link
// [RULE_15] zeros then thirty two ones reset all
// [RULE_16] host starts with a reset
// [RULE_17] every access starts with communications byte
// [RULE_18] host shifts zeros while reading
// [RULE_19] mode write clears status, aborts, starts mode
// [RULE_20] mode write address low bits pick channel
// [RULE_21] three bit mode field, listed codes
// [RULE_22] data register read clears channel ready
// [RULE_23] reserved mode code behaves as idle
`timescale 1ns/1ps
module adc_mode_sequencer_serial_ctrl #(
	parameter int NCH = 8,
	parameter int DW  = 24,
	parameter int TW  = 16
) (
	input  wire logic          clk,
	input  wire logic          nrst,
	input  wire logic          sclk,
	input  wire logic          cs_n,
	input  wire logic          din,
	output logic               dout,
	output logic               dout_oe,
	output logic               rdy_n,
	input  wire logic          two_wire_mode,
	input  wire logic [NCH-1:0] chan_enable,
	input  wire logic [NCH*TW-1:0] conv_time_flat,
	input  wire logic [DW-1:0] adc_sample,
	output logic               master_clock_output_pin,
	output logic               mclk_oe,
	output logic               converter_power_down,
	output logic               continuous_read_active,
	output logic               cal_strobe,
	output logic [1:0]         cal_kind,
	output logic [2:0]         cal_chan,
	output logic [DW-1:0]      cal_value
);
	import adc_seq_pkg::*;

	typedef enum logic [1:0] {ser_comm, ser_write, ser_read} ser_state_t;

	// ------------------------------------------------------------
	// reset release and input synchronisers
	// ------------------------------------------------------------
	logic rst_meta, rst_n, soft_rst_reg;
	logic sclk_meta, sclk_sync, sclk_prev, cs_meta, cs_n_sync, din_meta, din_sync;
	logic rise_act;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= !soft_rst_reg; // [RULE_15]
			rst_n    <= rst_meta;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_meta <= 1'b1;
			sclk_sync <= 1'b1;
			sclk_prev <= 1'b1;
			cs_meta   <= 1'b1;
			cs_n_sync <= 1'b1;
			din_meta  <= 1'b0;
			din_sync  <= 1'b0;
		end else begin
			sclk_meta <= sclk;
			sclk_sync <= sclk_meta;
			sclk_prev <= sclk_sync;
			cs_meta   <= cs_n;
			cs_n_sync <= cs_meta;
			din_meta  <= din;
			din_sync  <= din_meta;
		end
	end

	assign rise_act = sclk_sync && !sclk_prev && !cs_n_sync; // [RULE_12]

	// ------------------------------------------------------------
	// shared state declarations
	// ------------------------------------------------------------
	logic [7:0]     mode_reg;
	logic [2:0]     mode_field;
	logic           mode_wr;
	logic [2:0]     mode_wr_chan;
	logic [7:0]     mode_wr_val;
	logic [NCH-1:0] rdy_bits;
	logic [DW-1:0]  data_mem [NCH];
	logic [2:0]     last_chan;
	logic           data_rd;
	logic [2:0]     data_rd_chan;
	logic           data_rd_busy;

	assign mode_field = mode_reg[MODE_FIELD_HI:MODE_FIELD_LO];

	// ------------------------------------------------------------
	// serial port: communications byte then addressed register
	// ------------------------------------------------------------
	ser_state_t ser_state;
	logic [4:0] bit_cnt, frame_len;
	logic [7:0] rx_sh;
	logic [23:0] tx_sh;
	logic [5:0] addr_reg;
	logic       cont_active, cont_exit_req;
	logic [2:0] din_hi_cnt;
	logic [5:0] ones_cnt;
	logic       seen_zero;
	logic [7:0] comm_byte, wr_byte;
	logic [23:0] rd_word;
	logic [4:0] rd_len;
	logic [23:0] dump_word;
	logic [4:0] data_len;

	assign comm_byte = {rx_sh[6:0], din_sync};
	assign wr_byte   = comm_byte;
	assign data_len  = mode_reg[WIDTH24_BIT] ? LEN_WORD24 : LEN_WORD16;

	// status byte carries channel number, then top 16 data bits of last converted channel
	assign dump_word = {last_chan, 5'h00, data_mem[last_chan][DW-1:DW-16]};

	always_comb begin
		rd_word = 24'h00_0000;
		rd_len  = LEN_BYTE;
		if (comm_byte[5:0] == ADDR_STATUS) begin
			rd_word = {rdy_bits, 16'h0000};
		end else if (comm_byte[5:3] == ADDR_DATA_BASE[5:3]) begin
			rd_word = data_mem[comm_byte[2:0]];
			rd_len  = data_len;
		end else if (comm_byte[5:3] == ADDR_CHST_BASE[5:3]) begin
			rd_word = {comm_byte[2:0], 5'h00, 16'h0000};
		end else if (comm_byte[5:0] == ADDR_MODE_BASE) begin // [RULE_20]
			rd_word = {mode_reg, 16'h0000};
		end
	end

	assign data_rd      = rise_act && ser_state == ser_comm && !cont_active && bit_cnt == 5'h07
	                      && comm_byte[COMM_READ_BIT] && comm_byte[5:3] == ADDR_DATA_BASE[5:3]; // [RULE_22]
	assign data_rd_chan = comm_byte[2:0];
	assign data_rd_busy = ser_state == ser_read;
	assign mode_wr      = rise_act && ser_state == ser_write && bit_cnt == 5'h07
	                      && addr_reg[5:3] == ADDR_MODE_BASE[5:3];
	assign mode_wr_chan = addr_reg[2:0]; // [RULE_20]
	assign mode_wr_val  = wr_byte;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ser_state <= ser_comm;
			bit_cnt   <= 5'h00;
			frame_len <= LEN_BYTE;
			rx_sh     <= 8'h00;
			tx_sh     <= 24'h00_0000;
			addr_reg  <= 6'h00;
		end else if (cs_n_sync && !cont_active) begin
			ser_state <= ser_comm; // [RULE_12] [RULE_17]
			bit_cnt   <= 5'h00;
		end else if (cont_exit_req && ser_state == ser_read && bit_cnt == 5'h00) begin
			ser_state <= ser_comm;
		end else if (rise_act) begin
			bit_cnt <= bit_cnt + 5'h01;
			case (ser_state)
				ser_comm: begin
					rx_sh <= comm_byte;
					if (bit_cnt == 5'h07) begin // [RULE_17]
						bit_cnt  <= 5'h00;
						addr_reg <= comm_byte[5:0];
						if (comm_byte[COMM_READ_BIT]) begin
							ser_state <= ser_read;
							tx_sh     <= rd_word;
							frame_len <= rd_len;
							if (comm_byte == COMM_CONT_READ && mode_reg[CONT_READ_BIT] && !two_wire_mode) begin
								tx_sh     <= dump_word;
								frame_len <= LEN_BYTE + LEN_WORD16;
							end
						end else begin
							ser_state <= ser_write;
						end
					end
				end
				ser_write: begin
					rx_sh <= wr_byte;
					if (bit_cnt == 5'h07) begin
						ser_state <= ser_comm;
						bit_cnt   <= 5'h00;
					end
				end
				default: begin
					tx_sh <= {tx_sh[22:0], 1'b0};
					if (bit_cnt == frame_len - 5'h01) begin
						bit_cnt <= 5'h00;
						if (cont_active) begin
							tx_sh     <= dump_word;
							frame_len <= LEN_BYTE + LEN_WORD16;
						end else begin
							ser_state <= ser_comm;
						end
					end
				end
			endcase
		end
	end

	// continuous read: entered by the read command, left by din held high
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cont_active   <= 1'b0;
			cont_exit_req <= 1'b0;
			din_hi_cnt    <= 3'h0;
		end else begin
			if (two_wire_mode || mode_wr) begin
				cont_active <= 1'b0; // [RULE_14]
			end else if (rise_act && ser_state == ser_comm && bit_cnt == 5'h07 && comm_byte == COMM_CONT_READ
			             && mode_reg[CONT_READ_BIT]) begin
				cont_active <= 1'b1;
			end else if (cont_exit_req && bit_cnt == 5'h00) begin
				cont_active <= 1'b0;
			end
			if (!cont_active || !din_sync || bit_cnt != 5'h00)
				din_hi_cnt <= 3'h0;
			else if (din_hi_cnt != CONT_EXIT_CNT)
				din_hi_cnt <= din_hi_cnt + 3'h1;
			cont_exit_req <= cont_active && din_hi_cnt == CONT_EXIT_CNT;
		end
	end

	// serial reset pattern: zeros then a run of ones
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ones_cnt     <= 6'h00;
			seen_zero    <= 1'b0;
			soft_rst_reg <= 1'b0;
		end else if (rise_act) begin
			if (!din_sync) begin
				seen_zero <= 1'b1;
				ones_cnt  <= 6'h00;
			end else if (seen_zero && ones_cnt == RESET_ONES - 6'h01) begin
				soft_rst_reg <= 1'b1; // [RULE_15]
			end else begin
				ones_cnt <= ones_cnt + 6'h01;
			end
		end
	end

	assign dout    = tx_sh[23];
	assign dout_oe = !cs_n_sync && ser_state == ser_read; // [RULE_12]

	// ------------------------------------------------------------
	// conversion and calibration engine
	// ------------------------------------------------------------
	logic [2:0]    cur_chan;
	logic [TW-1:0] conv_cnt, cur_time;
	logic          running, is_conv, is_cal, eng_term, accept, done_fire;
	logic          fifo_in_ready;
	logic [2:0]    nxt_chan;

	function automatic logic [2:0] next_enabled(input logic [2:0] c, input logic [NCH-1:0] en);
		logic [2:0] r;
		r = c;
		for (int i = NCH - 1; i >= 1; i--) begin
			if (en[3'(c + 3'(i))])
				r = 3'(c + 3'(i));
		end
		return r;
	endfunction

	assign nxt_chan  = next_enabled(cur_chan, chan_enable); // [RULE_02]
	assign cur_time  = conv_time_flat[cur_chan*TW +: TW];
	assign is_conv   = mode_field == MODE_CONT || mode_field == MODE_SINGLE;
	assign is_cal    = mode_field == MODE_SELFCAL || mode_field == MODE_SYS_ZS || mode_field == MODE_SYS_FS;
	assign running   = is_conv || is_cal; // [RULE_23]
	assign eng_term  = conv_cnt + TW'(1) >= cur_time; // [RULE_04]
	assign accept    = is_cal || fifo_in_ready;
	assign done_fire = running && eng_term && accept && !mode_wr;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			conv_cnt <= '0;
			cur_chan <= 3'h0;
		end else if (mode_wr) begin
			conv_cnt <= '0; // [RULE_19]
			cur_chan <= mode_wr_chan; // [RULE_06]
		end else if (done_fire) begin
			conv_cnt <= '0;
			if (mode_field == MODE_CONT)
				cur_chan <= nxt_chan; // [RULE_03]
		end else if (running && !eng_term) begin
			conv_cnt <= conv_cnt + TW'(1);
		end
	end

	// mode register: written over serial, mode field cleared on one-shot finish
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_reg <= MODE_REG_RESET; // [RULE_01]
		end else if (mode_wr) begin
			mode_reg <= mode_wr_val; // [RULE_19] [RULE_21]
		end else if (done_fire && mode_field != MODE_CONT) begin
			mode_reg[MODE_FIELD_HI:MODE_FIELD_LO] <= MODE_IDLE; // [RULE_01] [RULE_05]
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cal_strobe <= 1'b0;
			cal_kind   <= CAL_ADC_ZS;
			cal_chan   <= 3'h0;
			cal_value  <= '0;
		end else begin
			cal_strobe <= done_fire && is_cal;
			if (done_fire && is_cal) begin
				cal_chan  <= cur_chan;
				cal_value <= adc_sample;
				if (mode_field == MODE_SELFCAL)
					cal_kind <= CAL_ADC_ZS; // [RULE_09]
				else if (mode_field == MODE_SYS_ZS)
					cal_kind <= CAL_CH_ZS; // [RULE_10]
				else
					cal_kind <= CAL_CH_FS; // [RULE_11]
			end
		end
	end

	// ------------------------------------------------------------
	// two-entry result buffer in front of the data registers
	// ------------------------------------------------------------
	logic [DW+2:0] fifo_mem [2];
	logic          fifo_wp, fifo_rp;
	logic [1:0]    fifo_cnt;
	logic          fifo_push, fifo_pop;
	logic [DW+2:0] fifo_head;

	assign fifo_in_ready = fifo_cnt != 2'h2;
	assign fifo_push     = done_fire && is_conv;
	assign fifo_pop      = fifo_cnt != 2'h0 && !data_rd_busy && !data_rd && !mode_wr;
	assign fifo_head     = fifo_mem[fifo_rp];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fifo_wp  <= 1'b0;
			fifo_rp  <= 1'b0;
			fifo_cnt <= 2'h0;
		end else if (mode_wr) begin
			fifo_wp  <= 1'b0; // stale results of the aborted mode are dropped
			fifo_rp  <= 1'b0;
			fifo_cnt <= 2'h0;
		end else begin
			if (fifo_push)
				fifo_wp <= !fifo_wp;
			if (fifo_pop)
				fifo_rp <= !fifo_rp;
			fifo_cnt <= fifo_cnt + 2'(fifo_push) - 2'(fifo_pop);
		end
	end

	always_ff @(posedge clk) begin
		if (fifo_push)
			fifo_mem[fifo_wp] <= {cur_chan, adc_sample};
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			last_chan <= 3'h0;
		end else if (fifo_pop) begin
			last_chan <= fifo_head[DW+2:DW];
		end
	end

	for (genvar g = 0; g < NCH; g++) begin : g_chan
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				data_mem[g] <= '0;
				rdy_bits[g] <= 1'b0;
			end else begin
				if (fifo_pop && fifo_head[DW+2:DW] == 3'(g))
					data_mem[g] <= fifo_head[DW-1:0]; // [RULE_02] [RULE_05]
				if (mode_wr)
					rdy_bits[g] <= 1'b0; // [RULE_19]
				else if ((fifo_pop && fifo_head[DW+2:DW] == 3'(g)) || (done_fire && is_cal))
					rdy_bits[g] <= 1'b1; // [RULE_02] [RULE_09] [RULE_10] [RULE_11]
				else if (data_rd && data_rd_chan == 3'(g))
					rdy_bits[g] <= 1'b0; // [RULE_22]
			end
		end
	end

	// ------------------------------------------------------------
	// pins
	// ------------------------------------------------------------
	logic mclk_div;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			mclk_div <= 1'b0;
		else
			mclk_div <= !mclk_div;
	end

	assign master_clock_output_pin = mclk_div;
	assign mclk_oe                 = !mode_reg[OUTCLK_OFF_BIT]; // [RULE_08]
	assign converter_power_down    = mode_field == MODE_STANDBY; // [RULE_07]
	assign rdy_n                   = !(|rdy_bits); // [RULE_13]
	assign continuous_read_active  = cont_active;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	AST_ONESHOT_IDLE: assert property (done_fire && mode_field != MODE_CONT |=> mode_field == MODE_IDLE) // [RULE_01]
		else $error("one-shot mode did not return to idle");
	AST_CONT_NEXT: assert property (done_fire && mode_field == MODE_CONT // [RULE_03]
		|=> cur_chan == $past(nxt_chan) && mode_field == MODE_CONT)
		else $error("continuous mode did not advance channel");
	AST_TERM_COUNT: assert property (done_fire |-> conv_cnt + TW'(1) >= cur_time) // [RULE_04]
		else $error("conversion finished early");
	AST_SINGLE_CHAN: assert property (mode_wr |=> cur_chan == $past(mode_wr_chan)) // [RULE_06]
		else $error("mode write channel not taken");
	AST_STANDBY_PD: assert property (mode_field == MODE_STANDBY |-> converter_power_down && !running) // [RULE_07]
		else $error("standby not powered down");
	AST_MCLK_OE: assert property ($changed(converter_power_down) && $stable(mode_reg[OUTCLK_OFF_BIT]) // [RULE_08]
		|-> $stable(mclk_oe))
		else $error("clock output follows standby");
	AST_CAL_RDY: assert property (done_fire && is_cal |=> &rdy_bits && !rdy_n && cal_strobe // [RULE_09]
		##1 !cal_strobe)
		else $error("calibration did not set all ready bits");
	AST_CS_HIZ: assert property (cs_n_sync |-> !dout_oe) // [RULE_12]
		else $error("output driven while deselected");
	AST_TWO_WIRE: assert property (two_wire_mode |=> !cont_active) // [RULE_14]
		else $error("continuous read on two-wire link");
	AST_MODE_WR: assert property (mode_wr |=> rdy_bits == '0 && rdy_n ##1 fifo_cnt <= 2'h1) // [RULE_19]
		else $error("mode write did not clear status");
	AST_RD_CLEAR: assert property (data_rd && !done_fire && !fifo_pop |=> !rdy_bits[$past(data_rd_chan)]) // [RULE_22]
		else $error("data read did not clear ready");
	AST_SOFT_RST: assert property (@(posedge clk) disable iff (!nrst) soft_rst_reg |=> !rst_meta ##1 !rst_n) // [RULE_15]
		else $error("serial reset pattern ignored");

	COV_SINGLE: cover property (mode_field == MODE_SINGLE ##[1:1000] !rdy_n);
	COV_CONT_WRAP: cover property (done_fire && mode_field == MODE_CONT ##[1:1000] done_fire && mode_field == MODE_CONT);
	COV_CAL: cover property (cal_strobe);
	COV_CONTINUOUS_READ_ENABLE: cover property (cont_active);
endmodule

// ===== adc_mode_sequencer_serial_ctrl_tb_top.sv
// self-checking bench for the mode sequencer and its serial port
`timescale 1ns/1ps
module adc_mode_sequencer_serial_ctrl_tb_top;
	import adc_seq_pkg::*;
	logic         clk;
	logic         nrst;
	logic         sclk;
	logic         cs_n;
	logic         din;
	logic         dout;
	logic         dout_oe;
	logic         rdy_n;
	logic         two_wire_mode;
	logic [7:0]   chan_enable;
	logic [127:0] conv_time_flat;
	logic [23:0]  adc_sample;
	logic         mclk_pin;
	logic         mclk_oe;
	logic         power_down;
	logic         cont_read_on;
	logic         cal_strobe;
	logic [1:0]   cal_kind;
	logic [2:0]   cal_chan;
	logic [23:0]  cal_value;
	logic [63:0]  r;
	logic [2:0]   cal_code [3];
	int           errors;
	int           checks_done;
	int           seed;
	int           ch;

	adc_mode_sequencer_serial_ctrl i_adc_mode_sequencer_serial_ctrl (
		.clk                     (clk),
		.nrst                    (nrst),
		.sclk                    (sclk),
		.cs_n                    (cs_n),
		.din                     (din),
		.dout                    (dout),
		.dout_oe                 (dout_oe),
		.rdy_n                   (rdy_n),
		.two_wire_mode           (two_wire_mode),
		.chan_enable             (chan_enable),
		.conv_time_flat          (conv_time_flat),
		.adc_sample              (adc_sample),
		.master_clock_output_pin (mclk_pin),
		.mclk_oe                 (mclk_oe),
		.converter_power_down    (power_down),
		.continuous_read_active  (cont_read_on),
		.cal_strobe              (cal_strobe),
		.cal_kind                (cal_kind),
		.cal_chan                (cal_chan),
		.cal_value               (cal_value)
	);

	serial_host_model i_serial_host_model (
		.clk  (clk),
		.sclk (sclk),
		.cs_n (cs_n),
		.din  (din),
		.dout (dout_oe ? dout : !dout)
	);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic stop_test();
		$display("checks=%0d errors=%0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	function automatic logic [7:0] mode_byte(input logic [2:0] code, input logic [4:0] low);
		return {code, low};
	endfunction

	function automatic logic [31:0] exp_data(input logic [23:0] s);
		return {16'h0000, s[23:8]};
	endfunction

	task automatic rd(input logic [5:0] a, input int n);
		i_serial_host_model.frame({56'h0, 2'b01, a} << n, 8 + n, r);
		r = r & ((64'h1 << n) - 64'h1);
		chk(32'($isunknown(rdy_n)), 0);
		chk(32'(dout_oe), 0);
	endtask

	task automatic wr(input int c, input logic [7:0] v);
		i_serial_host_model.frame({48'h0, 2'b00, ADDR_MODE_BASE | 6'(c), v}, 16, r);
	endtask

	// sel 0 waits for the ready pin low, sel 1 for the calibration strobe
	task automatic wait_ev(input bit sel, input int lim);
		int k;
		k = 0;
		while (!(sel ? cal_strobe === 1'b1 : rdy_n === 1'b0) && k < lim) begin
			@(posedge clk);
			#2;
			k++;
		end
		if (k >= lim) begin
			errors++;
			stop_test();
		end
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		seed = 32'h9a81_412a;
		errors = 0;
		checks_done = 0;
		nrst = 1'b0;
		two_wire_mode = 1'b0;
		chan_enable = 8'h00;
		adc_sample = 24'h00_0000;
		cal_code = '{MODE_SELFCAL, MODE_SYS_ZS, MODE_SYS_FS};
		for (int i = 0; i < 8; i++) begin
			conv_time_flat[i*16 +: 16] = 16'h0014 + 16'($random(seed) & 32'h0000_001f);
		end
		repeat (10) @(posedge clk);
		#2 nrst = 1'b1;
		repeat (6) @(posedge clk);
		#2;
		chk(32'(rdy_n), 1);
		chk(32'(mclk_oe), 1);
		rd(ADDR_MODE_BASE, 8);
		chk(r[31:0], 0);
		$display("test reset done");
		repeat (3) begin
			ch = $random(seed) & 7;
			adc_sample = 24'($random(seed));
			chan_enable = ~(8'h01 << ch);
			wr(ch, mode_byte(MODE_SINGLE, 5'h00));
			chk(32'(rdy_n), 1);
			wait_ev(0, 2000);
			rd(ADDR_STATUS, 8);
			chk(r[31:0], 32'h1 << ch);
			rd(ADDR_MODE_BASE, 8);
			chk(r[31:0], 0);
			rd(ADDR_DATA_BASE + 6'(ch), 16);
			chk(r[31:0], exp_data(adc_sample));
			chk(32'(rdy_n), 1);
		end
		$display("test single done");
		for (int i = 0; i < 3; i++) begin
			ch = $random(seed) & 7;
			adc_sample = 24'($random(seed));
			wr(ch, mode_byte(cal_code[i], 5'h00));
			wait_ev(1, 2000);
			chk(32'(cal_kind), i);
			if (i > 0) begin
				chk(32'(cal_chan), ch);
			end
			chk(32'(cal_value), 32'(adc_sample));
			wait_ev(0, 50);
			rd(ADDR_STATUS, 8);
			chk(r[31:0], 32'h0000_00ff);
			rd(ADDR_MODE_BASE, 8);
			chk(r[31:0], 0);
		end
		wr(0, mode_byte(MODE_IDLE, 5'h00));
		chk(32'(rdy_n), 1);
		rd(ADDR_STATUS, 8);
		chk(r[31:0], 0);
		$display("test calibration done");
		wr(0, mode_byte(MODE_STANDBY, 5'h00));
		chk(32'(power_down), 1);
		chk(32'(mclk_oe), 1);
		ch = int'(mclk_pin);
		@(posedge clk);
		#2 chk(32'(mclk_pin), 32'(ch ^ 1));
		rd(ADDR_MODE_BASE, 8);
		chk(r[31:0], 32'h0000_0060);
		wr(0, mode_byte(MODE_STANDBY, 5'h10));
		chk(32'(mclk_oe), 0);
		wr(0, mode_byte(MODE_IDLE, 5'h10));
		chk(32'(mclk_oe), 0);
		chk(32'(power_down), 0);
		$display("test standby done");
		chan_enable = 8'($random(seed)) | 8'h01;
		wr(0, mode_byte(MODE_CONT, 5'h00));
		repeat (900) @(posedge clk);
		rd(ADDR_STATUS, 8);
		chk(r[31:0], 32'(chan_enable));
		rd(ADDR_DATA_BASE, 16);
		chk(r[31:0], exp_data(adc_sample));
		repeat (900) @(posedge clk);
		rd(ADDR_STATUS, 8);
		chk(r[31:0], 32'(chan_enable));
		$display("test continuous done");
		wr(0, mode_byte(MODE_CONT, 5'h04));
		i_serial_host_model.frame({56'h0, COMM_CONT_READ}, 8, r);
		i_serial_host_model.frame(64'h0, 24, r);
		chk(32'(r[15:0]), exp_data(adc_sample));
		chk(32'(cont_read_on), 1);
		two_wire_mode = 1'b1;
		repeat (4) @(posedge clk);
		#2 chk(32'(cont_read_on), 0);
		two_wire_mode = 1'b0;
		wr(0, mode_byte(MODE_STANDBY, 5'h00));
		$display("test continuous read done");
		i_serial_host_model.frame(64'h0000_0000_ffff_ffff, 40, r);
		chk(32'(power_down), 0);
		rd(ADDR_MODE_BASE, 8);
		chk(r[31:0], 0);
		$display("test serial reset done");
		stop_test();
	end
endmodule

// ===== adc_seq_pkg.sv
// constants shared by the mode sequencer and its serial port
package adc_seq_pkg;
	// ------------------------------------------------------------
	// mode codes
	// ------------------------------------------------------------
	localparam logic [2:0] MODE_IDLE    = 3'h0;
	localparam logic [2:0] MODE_CONT    = 3'h1;
	localparam logic [2:0] MODE_SINGLE  = 3'h2;
	localparam logic [2:0] MODE_STANDBY = 3'h3;
	localparam logic [2:0] MODE_SELFCAL = 3'h4;
	localparam logic [2:0] MODE_RSVD    = 3'h5;
	localparam logic [2:0] MODE_SYS_ZS  = 3'h6;
	localparam logic [2:0] MODE_SYS_FS  = 3'h7;
	// ------------------------------------------------------------
	// mode register layout and reset value
	// ------------------------------------------------------------
	localparam int         MODE_FIELD_HI  = 7;
	localparam int         MODE_FIELD_LO  = 5;
	localparam int         OUTCLK_OFF_BIT = 4;
	localparam int         DUMP_BIT       = 3;
	localparam int         CONT_READ_BIT  = 2;
	localparam int         WIDTH24_BIT    = 1;
	localparam logic [7:0] MODE_REG_RESET = 8'h00;
	// ------------------------------------------------------------
	// communications byte and register addresses
	// ------------------------------------------------------------
	localparam int         COMM_READ_BIT  = 6;
	localparam logic [5:0] ADDR_STATUS    = 6'h04;
	localparam logic [5:0] ADDR_DATA_BASE = 6'h08;
	localparam logic [5:0] ADDR_CHST_BASE = 6'h20;
	localparam logic [5:0] ADDR_MODE_BASE = 6'h38;
	localparam logic [7:0] COMM_CONT_READ = 8'h48;
	// ------------------------------------------------------------
	// calibration kinds
	// ------------------------------------------------------------
	localparam logic [1:0] CAL_ADC_ZS = 2'h0;
	localparam logic [1:0] CAL_CH_ZS  = 2'h1;
	localparam logic [1:0] CAL_CH_FS  = 2'h2;
	// ------------------------------------------------------------
	// serial reset pattern and timing
	// ------------------------------------------------------------
	localparam logic [5:0] RESET_ONES         = 6'h20;
	localparam int         CLK_PERIOD_NS      = 25;
	localparam int         CONT_EXIT_NS       = 100;
	localparam int         CONT_EXIT_CYCLES   = (CONT_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [2:0] CONT_EXIT_CNT      = 3'(CONT_EXIT_CYCLES);
	localparam logic [4:0] LEN_BYTE           = 5'h08;
	localparam logic [4:0] LEN_WORD16         = 5'h10;
	localparam logic [4:0] LEN_WORD24         = 5'h18;
endpackage

// ===== serial_host_model.sv
// behavioural host serial port that drives the converter's link
`timescale 1ns/1ps
module serial_host_model (
	input  wire logic clk,
	output logic      sclk,
	output logic      cs_n,
	output logic      din,
	input  wire logic dout
);
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		din  = 1'b0;
	end

	// deselected data line toggles so a stale level never looks like data
	always @(posedge clk) begin
		if (cs_n) begin
			din <= ~din;
		end
	end

	// one chip-select frame, msb first, 8 clk per serial bit, dout taken before each rise
	task automatic frame(input logic [63:0] v, input int n, output logic [63:0] r);
		r = '0;
		@(posedge clk);
		#2 cs_n = 1'b0;
		repeat (3) @(posedge clk);
		for (int i = n - 1; i >= 0; i--) begin
			#2 sclk = 1'b0;
			din = v[i];
			repeat (3) @(posedge clk);
			r = {r[62:0], dout};
			@(posedge clk);
			#2 sclk = 1'b1;
			repeat (4) @(posedge clk);
		end
		#2 cs_n = 1'b1;
		repeat (4) @(posedge clk);
		#2;
	endtask
endmodule
